// file: pcs_fifo.sv
// Parameterised flip-flop FIFO and the reset synchroniser of the PCS block.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Reset synchroniser: asynchronous assertion, synchronous release.
module pcs_rst_sync
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Synchronised reset
   output logic o_rst_n
);
   typedef struct packed {
      logic [pcs_pkg::SYNC_STAGES-1:0] sh;
   } sync_st_t;

   sync_st_t st_r;
   sync_st_t st_nxt;

   always_comb
   begin
      st_nxt.sh = {st_r.sh[pcs_pkg::SYNC_STAGES-2:0], 1'b1};
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign o_rst_n = st_r.sh[pcs_pkg::SYNC_STAGES-1];
endmodule // pcs_rst_sync

// ============================================================================
// FIFO with valid/ready on both sides and a fill count.
module pcs_fifo
#(
   parameter int W = 36,
   parameter int D = 16,
   parameter int CW = 5
)
(
   // Clock, reset and flush
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_clr,
   // Fill side
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   // Drain side
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data,
   // Fill level
   output logic [CW-1:0] o_count
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [CW-1:0] wp;
      logic [CW-1:0] rp;
   } fifo_st_t;

   fifo_st_t st_r;
   fifo_st_t st_nxt;
   logic [CW-1:0] count;

   assign count = st_r.wp - st_r.rp;
   assign o_count = count;
   assign o_wr_ready = (count != CW'(D));
   assign o_rd_valid = (count != '0);
   assign o_rd_data = st_r.mem[st_r.rp[AW-1:0]];

   always_comb
   begin
      st_nxt = st_r;
      if (i_wr_valid && o_wr_ready)
      begin
         st_nxt.mem[st_r.wp[AW-1:0]] = i_wr_data;
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (i_rd_ready && o_rd_valid)
         st_nxt.rp = st_r.rp + 1'b1;
      // A flush drops stale words so a restart begins from an empty buffer.
      if (i_clr)
      begin
         st_nxt.wp = '0;
         st_nxt.rp = '0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
endmodule // pcs_fifo

`default_nettype wire

// file: pcs_pkg.sv
// Shared constants, column types and state enumerations for the PCS block.
package pcs_pkg;

   // ==========================================================================
   // Widths and depths
   localparam int LANES = 4;
   localparam int DATA_W = 32;
   localparam int COL_W = 36;
   localparam int FIFO_DEPTH = 16;
   // Midpoint of the transmit FIFO: 8 transfers, 32 bytes.
   localparam int FIFO_MID = 8;
   localparam int CNT_W = 5;
   localparam int IDLE_SETS = 8;
   localparam int IDLE_CNT_W = 4;
   localparam int SYNC_STAGES = 2;

   // ==========================================================================
   // Character codes
   localparam logic [7:0] CH_IDLE = 8'h07;
   localparam logic [7:0] CH_ALIGN = 8'h7C;
   localparam logic [7:0] CH_SKIP = 8'hBC;
   localparam logic [7:0] CH_REPL = 8'h1C;
   localparam logic [7:0] CH_START = 8'hFB;
   localparam logic [7:0] CH_TERM = 8'hFD;
   localparam logic [7:0] CH_ERR = 8'hFE;
   localparam logic [7:0] CH_SEQ = 8'h9C;
   localparam logic [3:0] CTRL_ALL = 4'hF;
   localparam logic [3:0] CTRL_LF = 4'h1;
   localparam logic [31:0] DATA_LF = 32'h0100009C;
   localparam logic [31:0] DATA_IDLE = 32'h07070707;
   localparam logic [31:0] DATA_ERR = 32'hFEFEFEFE;
   localparam logic [35:0] TOGGLE_PAT = 36'hAAAAAAAAA;
   localparam logic [CNT_W-1:0] MID_CNT = 5'h08;
   localparam logic [IDLE_CNT_W-1:0] IDLE_LAST = 4'h7;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic [3:0] ctrl;
      logic [31:0] data;
   } xgmii_col_t;

   typedef struct packed {
      xgmii_col_t col;
      logic valid;
      logic frame_err;
      logic decode_err;
   } serial_rx_t;

   localparam xgmii_col_t COL_LF = '{ctrl: CTRL_LF, data: DATA_LF};
   localparam xgmii_col_t COL_IDLE = '{ctrl: CTRL_ALL, data: DATA_IDLE};
   localparam xgmii_col_t COL_ERR = '{ctrl: CTRL_ALL, data: DATA_ERR};

   typedef enum logic [1:0] {TX_FAULT, TX_FILL, TX_RUN} tx_state_t;
   typedef enum logic [1:0] {RX_FAULT, RX_FILL, RX_RUN, RX_ERROR} rx_state_t;

endpackage

// file: pcs_startup_fault_control.sv
// Start-up sequencing, fault insertion and FIFO error handling of the PCS.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01: XGMII transmit clock is an input; receive clock comes from reference.
// R02: Serial receive clock is an input; transmit clock comes from reference.
// R03: The system keeps all four clock inputs running.
// R04: Management access needs no free-running management clock.
// R05: In reset, XGMII outputs and receive clock low; serial outputs toggle.
// R06: Reset should be held at least 1 us after valid power.
// R07: All clock inputs are valid when reset is released.
// R08: After reset, local fault and idle leave both FIFO outputs.
// R09: Transmit faults last until eight idle or replacement sets arrive.
// R10: Transmit FIFO drains only after filling to its midpoint.
// R11: Drained transmit data passes the encoder before the serial bus.
// R12: Receive faults last until frame lock; then data flows via FIFO.
// R13: Management commands are accepted right after reset release.
// R14: Frame sync restarts on reset; link is down while faults generate.
// R15: Receive detects framing/decode errors; transmit detects encode errors.
// R16: Detected bit errors are replaced by the error control character.
// R17: Loss of receive lock resumes local faults until lock returns.
// R18: FIFO overrun/underrun sets sticky error, drops link, sends faults.
// R19: Receive overflow and underflow latch into self-clearing read bits.
// R20: External reset is synchronised: asynchronous assert, clocked release.
module pcs_startup_fault_control
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_soft_rst,
   // XGMII transmit side
   input wire logic i_xgmii_tx_clock_in,
   input wire pcs_pkg::xgmii_col_t i_xgmii_tx,
   input wire logic i_xgmii_tx_valid,
   output logic o_xgmii_tx_ready,
   // XGMII receive side
   input wire logic i_xgmii_reference_clock,
   output logic o_xgmii_rx_clock_out,
   output pcs_pkg::xgmii_col_t o_xgmii_rx,
   // Serial side
   input wire logic i_serial_rx_clock_in,
   input wire pcs_pkg::serial_rx_t i_serial_rx,
   input wire logic i_frame_lock,
   input wire logic i_serial_side_reference_clock,
   output logic o_serial_tx_clock_out,
   input wire logic i_serial_tx_ready,
   output pcs_pkg::xgmii_col_t o_serial_tx,
   // Status
   input wire logic i_status_read,
   output logic o_link_up,
   output logic o_fifo_error,
   output logic o_rx_fifo_overflow_flag,
   output logic o_rx_fifo_underflow_flag,
   output logic o_mgmt_ready
);

   // =========================================================================
   // Character decoding

   function automatic logic ipg_char(input logic [7:0] ch);
      return (ch == pcs_pkg::CH_IDLE) || (ch == pcs_pkg::CH_ALIGN) ||
             (ch == pcs_pkg::CH_SKIP) || (ch == pcs_pkg::CH_REPL);
   endfunction

   function automatic logic ctrl_legal(input logic [7:0] ch);
      return ipg_char(ch) || (ch == pcs_pkg::CH_START) ||
             (ch == pcs_pkg::CH_TERM) || (ch == pcs_pkg::CH_ERR) ||
             (ch == pcs_pkg::CH_SEQ);
   endfunction

   function automatic logic ipg_col(input pcs_pkg::xgmii_col_t c);
      logic ok;
      ok = (c.ctrl == pcs_pkg::CTRL_ALL);
      for (int i = 0; i < pcs_pkg::LANES; i++)
         ok = ok && ipg_char(c.data[8*i +: 8]);
      return ok;
   endfunction

   // =========================================================================
   // State

   typedef struct packed {
      pcs_pkg::tx_state_t tx_st;
      pcs_pkg::rx_state_t rx_st;
      logic [pcs_pkg::IDLE_CNT_W-1:0] idle_cnt;
      logic lf_phase;
      pcs_pkg::xgmii_col_t tx_out;
      pcs_pkg::xgmii_col_t rx_out;
      logic link_up;
      logic fifo_err;
      logic ovfl;
      logic unfl;
   } st_t;

   st_t st_r;
   st_t st_nxt;
   logic rst_ok_n;
   logic tx_wr_valid;
   logic tx_wr_ready;
   logic tx_rd_valid;
   logic tx_rd_ready;
   pcs_pkg::xgmii_col_t tx_rd_data;
   logic [pcs_pkg::CNT_W-1:0] tx_cnt;
   logic rx_wr_valid;
   logic rx_wr_ready;
   logic rx_rd_valid;
   logic rx_rd_ready;
   pcs_pkg::xgmii_col_t rx_rd_data;
   pcs_pkg::xgmii_col_t rx_wr_data;
   logic [pcs_pkg::CNT_W-1:0] rx_cnt;
   logic tx_ovf;
   logic tx_unf;
   logic rx_ovf;
   logic rx_unf;
   logic rx_bit_err;
   logic tx_clr;
   logic rx_clr;
   wire [pcs_pkg::DATA_W-1:0] enc_data;
   pcs_pkg::xgmii_col_t enc_col;
   pcs_pkg::xgmii_col_t fault_col;

   // =========================================================================
   // Reset synchronisation

   // R20: reset synchroniser
   pcs_rst_sync u_rst_sync
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .o_rst_n(rst_ok_n)
   );

   // =========================================================================
   // Transmit path

   // R09: gate FIFO fill
   assign tx_wr_valid = (st_r.tx_st != pcs_pkg::TX_FAULT) && i_xgmii_tx_valid;
   // R10: drain after midpoint
   assign tx_rd_ready = (st_r.tx_st == pcs_pkg::TX_RUN) && i_serial_tx_ready;
   assign tx_ovf = tx_wr_valid && !tx_wr_ready;
   assign tx_unf = tx_rd_ready && !tx_rd_valid;
   assign tx_clr = (st_r.tx_st == pcs_pkg::TX_FAULT);
   assign o_xgmii_tx_ready = tx_wr_ready && rst_ok_n;

   pcs_fifo
   #(
      .W(pcs_pkg::COL_W),
      .D(pcs_pkg::FIFO_DEPTH),
      .CW(pcs_pkg::CNT_W)
   )
   u_tx_fifo
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_ok_n),
      .i_clr(tx_clr),
      .i_wr_valid(tx_wr_valid),
      .o_wr_ready(tx_wr_ready),
      .i_wr_data(i_xgmii_tx),
      .o_rd_valid(tx_rd_valid),
      .i_rd_ready(tx_rd_ready),
      .o_rd_data(tx_rd_data),
      .o_count(tx_cnt)
   );

   // R15: encode-time check
   // An undefined control code is the only error the encoder can see.
   for (genvar g = 0; g < pcs_pkg::LANES; g++)
   begin : g_enc_lane
      // R16: substitute error char
      assign enc_data[8*g +: 8] =
         (tx_rd_data.ctrl[g] && !ctrl_legal(tx_rd_data.data[8*g +: 8])) ?
         pcs_pkg::CH_ERR : tx_rd_data.data[8*g +: 8];
   end

   assign enc_col = '{ctrl: tx_rd_data.ctrl, data: enc_data};
   // R08: alternate fault and idle
   assign fault_col = st_r.lf_phase ? pcs_pkg::COL_IDLE : pcs_pkg::COL_LF;

   // =========================================================================
   // Receive path

   // R15: receive error detect
   assign rx_bit_err = i_serial_rx.frame_err || i_serial_rx.decode_err;
   // R16: replace bad column
   assign rx_wr_data = rx_bit_err ? pcs_pkg::COL_ERR : i_serial_rx.col;
   // R12: forward only while locked
   assign rx_wr_valid = ((st_r.rx_st == pcs_pkg::RX_FILL) ||
                         (st_r.rx_st == pcs_pkg::RX_RUN)) &&
                        i_serial_rx.valid && i_frame_lock;
   assign rx_rd_ready = (st_r.rx_st == pcs_pkg::RX_RUN);
   assign rx_ovf = rx_wr_valid && !rx_wr_ready;
   assign rx_unf = rx_rd_ready && !rx_rd_valid;
   assign rx_clr = (st_r.rx_st == pcs_pkg::RX_FAULT) ||
                   (st_r.rx_st == pcs_pkg::RX_ERROR);

   pcs_fifo
   #(
      .W(pcs_pkg::COL_W),
      .D(pcs_pkg::FIFO_DEPTH),
      .CW(pcs_pkg::CNT_W)
   )
   u_rx_fifo
   (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_ok_n),
      .i_clr(rx_clr),
      .i_wr_valid(rx_wr_valid),
      .o_wr_ready(rx_wr_ready),
      .i_wr_data(rx_wr_data),
      .o_rd_valid(rx_rd_valid),
      .i_rd_ready(rx_rd_ready),
      .o_rd_data(rx_rd_data),
      .o_count(rx_cnt)
   );

   // =========================================================================
   // Next state

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.lf_phase = ~st_r.lf_phase;
      unique case (st_r.tx_st)
         pcs_pkg::TX_FAULT:
         begin
            // R09: count idle sets
            if (i_xgmii_tx_valid && ipg_col(i_xgmii_tx))
            begin
               if (st_r.idle_cnt == pcs_pkg::IDLE_LAST)
                  st_nxt.tx_st = pcs_pkg::TX_FILL;
               st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
            end
            else if (i_xgmii_tx_valid)
               st_nxt.idle_cnt = '0;
         end
         pcs_pkg::TX_FILL:
         begin
            // R10: wait for midpoint
            if (tx_cnt >= pcs_pkg::MID_CNT)
               st_nxt.tx_st = pcs_pkg::TX_RUN;
         end
         pcs_pkg::TX_RUN:
         begin
            st_nxt.tx_st = pcs_pkg::TX_RUN;
         end
         default:
         begin
            st_nxt.tx_st = pcs_pkg::TX_FAULT;
         end
      endcase
      // R11: encoder output stage
      if (i_serial_tx_ready)
         st_nxt.tx_out = (tx_rd_ready && tx_rd_valid) ? enc_col : fault_col;

      unique case (st_r.rx_st)
         pcs_pkg::RX_FAULT:
         begin
            // R12: wait for frame lock
            if (i_frame_lock)
               st_nxt.rx_st = pcs_pkg::RX_FILL;
         end
         pcs_pkg::RX_FILL:
         begin
            // R17: lock lost
            if (!i_frame_lock)
               st_nxt.rx_st = pcs_pkg::RX_FAULT;
            else if (rx_cnt >= pcs_pkg::MID_CNT)
               st_nxt.rx_st = pcs_pkg::RX_RUN;
         end
         pcs_pkg::RX_RUN:
         begin
            // R17: lock lost
            if (!i_frame_lock)
               st_nxt.rx_st = pcs_pkg::RX_FAULT;
         end
         pcs_pkg::RX_ERROR:
         begin
            st_nxt.rx_st = pcs_pkg::RX_ERROR;
         end
      endcase

      // R18: sticky FIFO error
      if (tx_ovf || tx_unf || rx_ovf || rx_unf)
      begin
         st_nxt.fifo_err = 1'b1;
         st_nxt.rx_st = pcs_pkg::RX_ERROR;
      end
      // R19: latch, clear on read, set wins
      st_nxt.ovfl = rx_ovf || (st_r.ovfl && !i_status_read);
      st_nxt.unfl = rx_unf || (st_r.unfl && !i_status_read);

      // R14: soft reset restarts sync
      if (i_soft_rst)
      begin
         st_nxt.tx_st = pcs_pkg::TX_FAULT;
         st_nxt.rx_st = pcs_pkg::RX_FAULT;
         st_nxt.idle_cnt = '0;
         st_nxt.fifo_err = 1'b0;
      end

      // R08: fault insertion at FIFO output
      st_nxt.rx_out = (rx_rd_ready && rx_rd_valid) ? rx_rd_data : fault_col;
      // R14: link down while faults
      st_nxt.link_up = (st_nxt.rx_st == pcs_pkg::RX_RUN) && !st_nxt.fifo_err;
   end

   // R05: reset holds outputs low
   always_ff @(posedge i_sys_clk or negedge rst_ok_n)
   begin
      if (!rst_ok_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // =========================================================================
   // Outputs

   // R01: receive clock from reference
   assign o_xgmii_rx_clock_out = i_xgmii_reference_clock && rst_ok_n;
   // R02: serial transmit clock
   assign o_serial_tx_clock_out = i_serial_side_reference_clock;
   // R05: serial outputs keep toggling
   // The serial lines must not sit still in reset, so the pattern follows the clock.
   assign o_serial_tx = rst_ok_n ? st_r.tx_out : pcs_pkg::xgmii_col_t'(
      {pcs_pkg::COL_W{i_serial_side_reference_clock}} ^ pcs_pkg::TOGGLE_PAT);
   assign o_xgmii_rx = st_r.rx_out;
   assign o_link_up = st_r.link_up;
   assign o_fifo_error = st_r.fifo_err;
   assign o_rx_fifo_overflow_flag = st_r.ovfl;
   assign o_rx_fifo_underflow_flag = st_r.unfl;
   // R13: management ready at release
   // R04: level only, independent of any management clock edge
   assign o_mgmt_ready = rst_ok_n;

   // =========================================================================
   // Assertions

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!rst_ok_n);

   a_idle_count_gate: assert property ( // R09
      (st_r.tx_st == pcs_pkg::TX_FAULT) &&
      (st_nxt.tx_st == pcs_pkg::TX_FILL) |->
      (st_r.idle_cnt == pcs_pkg::IDLE_LAST) && ipg_col(i_xgmii_tx))
      else $error("transmit left fault without eight idle sets");

   a_mid_fill_gate: assert property ( // R10
      (st_r.tx_st == pcs_pkg::TX_FILL) && (tx_cnt < pcs_pkg::MID_CNT)
      |=> (st_r.tx_st != pcs_pkg::TX_RUN))
      else $error("transmit FIFO drained before midpoint");

   a_tx_fault_out: assert property ( // R08
      rst_ok_n && (st_r.tx_st != pcs_pkg::TX_RUN) && i_serial_tx_ready |=>
      (o_serial_tx == pcs_pkg::COL_LF) || (o_serial_tx == pcs_pkg::COL_IDLE))
      else $error("transmit output not fault or idle before run");

   a_lock_loss_fault: assert property ( // R17
      !i_frame_lock |=> ##1 (o_xgmii_rx == pcs_pkg::COL_LF) ||
      (o_xgmii_rx == pcs_pkg::COL_IDLE))
      else $error("receive output not fault after lock loss");

   a_link_down_fault: assert property ( // R14
      o_link_up |-> (st_r.rx_st == pcs_pkg::RX_RUN) && !o_fifo_error)
      else $error("link up while faults generated");

   a_rx_err_subst: assert property ( // R16
      rx_wr_valid && rx_bit_err |-> (rx_wr_data == pcs_pkg::COL_ERR))
      else $error("bit error not replaced by error column");

   a_fifo_err_sticky: assert property ( // R18
      o_fifo_error && !i_soft_rst |=> o_fifo_error && !o_link_up)
      else $error("FIFO error cleared without reset");

   a_ovfl_flag_set: assert property ( // R19
      rx_ovf |=> o_rx_fifo_overflow_flag [*2] or
      (o_rx_fifo_overflow_flag ##1 $past(i_status_read)))
      else $error("overflow event not latched");

   a_reset_outs_low: assert property ( // R05
      @(posedge i_sys_clk) disable iff (1'b0)
      !rst_ok_n |-> (o_xgmii_rx == '0) && !o_xgmii_rx_clock_out)
      else $error("XGMII outputs not low in reset");

   c_tx_run: cover property (st_r.tx_st == pcs_pkg::TX_RUN);
   c_rx_run: cover property (o_link_up ##1 !i_frame_lock);
   c_fifo_err: cover property ($rose(o_fifo_error));
   c_flag_read: cover property (o_rx_fifo_underflow_flag && i_status_read);

endmodule // pcs_startup_fault_control

`default_nettype wire

// file: serdes_model.sv
// Behavioural model of the serializer/deserializer at the block's far side.
`timescale 1ns/1ps
`default_nettype none

module serdes_model
(
   // Clock
   input wire logic i_sys_clk,
   // Commands from the bench
   input wire logic i_lock,
   input wire logic i_feed,
   input wire logic i_send_data,
   input wire logic i_inject,
   input wire logic i_stall_all,
   // Toward the design
   output var pcs_pkg::serial_rx_t o_serial_rx,
   output logic o_frame_lock,
   output logic o_tx_ready,
   // Column the design should forward, for the bench
   output logic o_sent_v,
   output var pcs_pkg::xgmii_col_t o_sent
);
   pcs_pkg::serial_rx_t nxt;
   int unsigned n;

   initial
   begin
      n = 0;
      o_serial_rx = '0;
      o_frame_lock = 1'b0;
      o_tx_ready = 1'b0;
      o_sent_v = 1'b0;
      o_sent = '0;
   end

   // ==========================================================================
   // Receive columns and transmit acceptance
   always @(posedge i_sys_clk)
   begin
      n = n + 1;
      nxt = o_serial_rx;
      nxt.valid = i_feed;
      nxt.frame_err = 1'b0;
      nxt.decode_err = 1'b0;
      // An idle line must not look like a held column, so it keeps changing.
      if (!i_feed)
         nxt.col = ~o_serial_rx.col;
      else if (i_send_data)
      begin
         nxt.col = '{ctrl: 4'h0, data: $urandom()};
         nxt.frame_err = i_inject && (n % 5 == 1);
         nxt.decode_err = i_inject && (n % 5 == 3);
      end
      else
         nxt.col = pcs_pkg::COL_IDLE;
      o_serial_rx <= nxt;
      o_sent_v <= i_feed && i_send_data && i_lock;
      o_sent <= (nxt.frame_err || nxt.decode_err) ? pcs_pkg::COL_ERR : nxt.col;
      o_frame_lock <= i_lock;
      // The gearbox is slow: it skips every fourth cycle.
      o_tx_ready <= !i_stall_all && (n % 4 != 0);
   end
endmodule // serdes_model

`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the PCS start-up and fault control block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic sys_clk = 1'b0, rst_n = 1'b0, soft_rst = 1'b0, tx_clk = 1'b0;
   logic xref = 1'b0, srx_clk = 1'b0, sref = 1'b0, tx_v = 1'b0;
   logic status_rd = 1'b0, lock_cmd = 1'b0, feed = 1'b0, live = 1'b0;
   logic send_data = 1'b0, inject = 1'b0, stall_all = 1'b0, rdy_q = 1'b0;
   pcs_pkg::xgmii_col_t tx_col = '0, rx_col, ser_tx, sent, rx_exp, tx_exp;
   pcs_pkg::serial_rx_t ser_rx;
   logic tx_ready, rxclk, ser_txclk, link_up, fifo_err, ovf, unf, mgmt_ready;
   logic frame_lock, ser_rdy, sent_v;
   pcs_pkg::xgmii_col_t rxq[$], txq[$];
   int errors = 0, check_count = 0, nput = 0;

   always #5 sys_clk = ~sys_clk;
   always #3.2 tx_clk = ~tx_clk;
   always #3.3 xref = ~xref;
   always #3.4 srx_clk = ~srx_clk;
   always #3.1 sref = ~sref;

   pcs_startup_fault_control dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
      .i_soft_rst(soft_rst), .i_xgmii_tx_clock_in(tx_clk),
      .i_xgmii_tx(tx_col), .i_xgmii_tx_valid(tx_v),
      .o_xgmii_tx_ready(tx_ready), .i_xgmii_reference_clock(xref),
      .o_xgmii_rx_clock_out(rxclk), .o_xgmii_rx(rx_col),
      .i_serial_rx_clock_in(srx_clk), .i_serial_rx(ser_rx),
      .i_frame_lock(frame_lock), .i_serial_side_reference_clock(sref),
      .o_serial_tx_clock_out(ser_txclk), .i_serial_tx_ready(ser_rdy),
      .o_serial_tx(ser_tx), .i_status_read(status_rd), .o_link_up(link_up),
      .o_fifo_error(fifo_err), .o_rx_fifo_overflow_flag(ovf),
      .o_rx_fifo_underflow_flag(unf), .o_mgmt_ready(mgmt_ready));

   serdes_model far_end (.i_sys_clk(sys_clk), .i_lock(lock_cmd),
      .i_feed(feed), .i_send_data(send_data), .i_inject(inject),
      .i_stall_all(stall_all), .o_serial_rx(ser_rx),
      .o_frame_lock(frame_lock), .o_tx_ready(ser_rdy), .o_sent_v(sent_v),
      .o_sent(sent));

   // ==========================================================================
   // Shared tasks
   task automatic chk(input string what, input logic [35:0] e,
                      input logic [35:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic put(input pcs_pkg::xgmii_col_t c,
                      input pcs_pkg::xgmii_col_t e, input bit note,
                      input bit gap);
      if (gap && (nput % 4 == 3))
      begin
         @(posedge sys_clk);
         tx_v <= 1'b0;
      end
      @(posedge sys_clk);
      tx_v <= 1'b1;
      tx_col <= c;
      nput++;
      if (note)
         txq.push_back(e);
   endtask

   task automatic pulse_soft();
      @(posedge sys_clk);
      tx_v <= 1'b0;
      soft_rst <= 1'b1;
      @(posedge sys_clk);
      soft_rst <= 1'b0;
   endtask

   task automatic expect_lf(input string what);
      logic seen;
      seen = 1'b0;
      repeat (4)
      begin
         @(negedge sys_clk);
         if (rx_col === pcs_pkg::COL_LF)
            seen = 1'b1;
      end
      chk(what, 36'h1, 36'(seen));
   endtask

   task automatic reset_checks();
      @(negedge sref);
      #1;
      chk("serial tx ref low", pcs_pkg::TOGGLE_PAT, ser_tx);
      @(posedge sref);
      #1;
      chk("serial tx ref high", ~pcs_pkg::TOGGLE_PAT, ser_tx);
      chk("serial tx clock", 36'(sref), 36'(ser_txclk));
      chk("xgmii rx column", 36'h0, rx_col);
      chk("xgmii rx clock", 36'h0, 36'(rxclk));
      chk("xgmii tx ready", 36'h0, 36'(tx_ready));
      chk("link in reset", 36'h0, 36'(link_up));
   endtask

   task automatic after_release();
      cyc(2);
      @(negedge sys_clk);
      chk("management ready", 36'h1, 36'(mgmt_ready));
      @(posedge xref) #1;
      chk("rx clock follows ref", 36'h1, 36'(rxclk));
      expect_lf("fault after reset");
      chk("link during fault", 36'h0, 36'(link_up));
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================================
   // Result watchers: the oldest note is taken whenever a column other than fault or idle appears (transmit: after a ready cycle).
   always @(posedge sys_clk) rdy_q <= ser_rdy;
   always @(posedge sys_clk) if (sent_v) rxq.push_back(sent);

   always @(negedge sys_clk)
   begin
      if (live && rx_col !== pcs_pkg::COL_LF && rx_col !== pcs_pkg::COL_IDLE)
      begin
         rx_exp = (rxq.size() > 0) ? rxq.pop_front() : ~rx_col;
         chk("xgmii rx column", rx_exp, rx_col);
      end
      if (live && rdy_q && ser_tx !== pcs_pkg::COL_LF
          && ser_tx !== pcs_pkg::COL_IDLE)
      begin
         tx_exp = (txq.size() > 0) ? txq.pop_front() : ~ser_tx;
         chk("serial tx column", tx_exp, ser_tx);
      end
   end

   initial
   begin
      cyc(6000);
      errors++;
      $display("wrong value watchdog expected finish seen hang");
      conclude();
   end

   // ==========================================================================
   // Test sequence
   initial
   begin
      pcs_pkg::xgmii_col_t c;
      pcs_pkg::xgmii_col_t e;
      void'($urandom(98));
      fork
         reset_checks();
         cyc(2);
      join
      rst_n <= 1'b1;
      after_release();
      $display("test reset done");

      @(posedge sys_clk);
      lock_cmd <= 1'b1;
      feed <= 1'b1;
      live <= 1'b1;
      cyc(20);
      chk("link after lock", 36'h1, 36'(link_up));
      send_data <= 1'b1;
      inject <= 1'b1;
      cyc(30);
      send_data <= 1'b0;
      cyc(15);
      chk("rx notes left", 36'h0, 36'(rxq.size()));
      $display("test receive done");

      lock_cmd <= 1'b0;
      cyc(4);
      chk("link after lock loss", 36'h0, 36'(link_up));
      expect_lf("fault after lock loss");
      lock_cmd <= 1'b1;
      cyc(20);
      chk("link after relock", 36'h1, 36'(link_up));
      $display("test lock loss done");

      for (int r = 0; r < 3; r++)
      begin
         for (int i = 0; i < 7 + (r / 2); i++)
            put((i == r) ? 36'hF1CBC7C07 : pcs_pkg::COL_IDLE, '0, 1'b0,
               1'b0);
         if (r < 2)
            put('{ctrl: 4'h0, data: 32'h0BAD0000 + r}, '0, 1'b0, 1'b0);
      end
      for (int i = 0; i < 40; i++)
      begin
         c = '{ctrl: 4'h0, data: $urandom()};
         e = c;
         if (i == 13)
         begin
            c = '{ctrl: 4'h1, data: 32'h33221155};
            e = '{ctrl: 4'h1, data: 32'h332211FE};
         end
         put(c, e, 1'b1, 1'b1);
         if (i == 7)
         begin
            @(negedge sys_clk);
            chk("tx held below midpoint", 36'h1, 36'(ser_tx ===
               pcs_pkg::COL_LF || ser_tx === pcs_pkg::COL_IDLE));
         end
      end
      for (int i = 0; i < 200 && txq.size() > 0; i++)
         put(pcs_pkg::COL_IDLE, '0, 1'b0, 1'b1);
      chk("tx notes left", 36'h0, 36'(txq.size()));
      pulse_soft();
      cyc(20);
      $display("test transmit done");

      feed <= 1'b0;
      cyc(15);
      @(negedge sys_clk);
      chk("error after underflow", 36'h1, 36'(fifo_err));
      chk("underflow flag", 36'h1, 36'(unf));
      chk("overflow flag apart", 36'h0, 36'(ovf));
      chk("link after underflow", 36'h0, 36'(link_up));
      expect_lf("fault after underflow");
      @(posedge sys_clk);
      status_rd <= 1'b1;
      @(posedge sys_clk);
      status_rd <= 1'b0;
      @(negedge sys_clk);
      chk("flag after read", 36'h0, 36'(unf));
      chk("error persists", 36'h1, 36'(fifo_err));
      feed <= 1'b1;
      pulse_soft();
      @(negedge sys_clk);
      chk("error after soft reset", 36'h0, 36'(fifo_err));
      cyc(20);
      chk("link after soft reset", 36'h1, 36'(link_up));
      $display("test underflow done");

      stall_all <= 1'b1;
      for (int i = 0; i < 40; i++)
         put(pcs_pkg::COL_IDLE, '0, 1'b0, 1'b0);
      @(negedge sys_clk);
      chk("error after overflow", 36'h1, 36'(fifo_err));
      chk("link after overflow", 36'h0, 36'(link_up));
      chk("tx ready when full", 36'h0, 36'(tx_ready));
      expect_lf("fault after overflow");
      stall_all <= 1'b0;
      pulse_soft();
      $display("test overflow done");

      @(posedge sys_clk);
      live <= 1'b0;
      rst_n <= 1'b0;
      reset_checks();
      cyc(100);
      rst_n <= 1'b1;
      after_release();
      $display("test second reset done");
      conclude();
   end
endmodule // testbench

`default_nettype wire
